// ===== verilog/lps_pkg.sv
// constants and types of the stop-mode controller
package lps_pkg;
    // register byte offsets
    localparam logic [7:0] LPS_CTRL_OFS = 8'h00;
    localparam logic [7:0] LPS_STAT_OFS = 8'h04;
    localparam logic [7:0] LPS_ACK_OFS = 8'h08;
    // control register field positions
    localparam int CTRL_DBG_EN = 0;
    localparam int CTRL_LVM_EN = 1;
    localparam int CTRL_LVM_STOP = 2;
    localparam int CTRL_PDS = 3;
    localparam int CTRL_STOP_EN = 4;
    localparam int CTRL_ICS_RUN = 5;
    localparam int CTRL_ADC_ASYNC = 6;
    localparam int CTRL_LVM_RST = 7;
    localparam int CTRL_RTI_EN = 8;
    localparam int CTRL_W = 9;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
    // status register field positions
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_WAKE_FLAG = 4;
    localparam int STAT_LATCH = 5;
    localparam int STAT_LVM_LOW = 6;
    // acknowledge register field position
    localparam int ACK_PD = 0;
    // pin synchroniser reset values: reset pin, irq pin, monitor
    localparam logic [2:0] PIN_SYNC_RST = 3'h3;

    typedef enum logic [3:0] {
        LPS_RUN = 4'h1,
        LPS_LIGHT = 4'h2,
        LPS_DEEP = 4'h4,
        LPS_DEBUG = 4'h8
    } lps_mode_t;

    typedef enum logic [2:0] {
        CMD_MEM = 3'h0,
        CMD_MEM_STAT = 3'h1,
        CMD_BDC_REG = 3'h2,
        CMD_BACKGROUND = 3'h3,
        CMD_CPU_REG = 3'h4,
        CMD_TRACE = 3'h5,
        CMD_GO = 3'h6
    } lps_cmd_t;

    typedef enum logic [1:0] {
        RSP_OK = 2'h0,
        RSP_STOPPED = 2'h1,
        RSP_REJECT = 2'h2
    } lps_rsp_t;

    typedef enum logic [1:0] {
        PWR_ON = 2'h0,
        PWR_STANDBY = 2'h1,
        PWR_OFF = 2'h2
    } lps_lvl_t;

    typedef struct packed {
        logic debug_clk_en;
        logic periph_clk_en;
        logic ics_on;
        logic reg_full;
        logic rti_on;
        logic pin_hold;
        lps_lvl_t cpu_flash;
        lps_lvl_t ram;
        lps_lvl_t ports;
        lps_lvl_t timers;
        lps_lvl_t adc;
    } lps_power_t;
endpackage

// ===== verilog/lps_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
module lps_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    genvar i;
    // one flop pair per bit; first stage feeds only the second
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic meta_r;
            logic sync_r;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    meta_r <= INIT[i];
                    sync_r <= INIT[i];
                end
                else if (ce)
                begin
                    meta_r <= d[i];
                    sync_r <= meta_r;
                end
            end
            assign q[i] = sync_r;
        end
    endgenerate
endmodule

// ===== verilog/lps_stop_ctrl.sv
// stop-level controller with debug and voltage monitor overrides
`timescale 1ns/100ps
//
// Behaviour
// - debug mode from run entered only while debug entry enable set
// - stop with debug enable keeps debug clocks running
// - stop with debug enable keeps regulator in full regulation
// - deep stop request with debug enable enters light stop
// - in stop, memory-with-status commands do no access, return stop error
// - background command wakes stop into debug only if debug enabled
// - after such a wake, debug mode accepts every command
// - debug light stop keeps clock source and regulator active
// - voltage monitor raises interrupt or reset, as configured
// - monitor and monitor-in-stop enabled keep regulator active in stop
// - deep stop request with monitor in stop enters light stop
// - monitor light stop: clock source off unless set to run
// - any stop gates peripheral clocks, even with debug clocks on
// - deep stop turns blocks off but keeps RAM in standby; light stop puts them in standby
// - light stop ADC runs only with async clock and monitor enabled
// - stop with stop enable clear forces illegal-opcode reset
// - deep stop only when power-down select and stop enable set
// - deep wake sets flag, holds pin latches until acknowledge write
// - light stop exits on reset pin or listed interrupt sources
module lps_stop_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_stop_exec,
    input wire logic dbg_cmd_valid,
    input wire lps_pkg::lps_cmd_t dbg_cmd,
    output logic dbg_rsp_valid,
    output lps_pkg::lps_rsp_t dbg_rsp,
    output logic dbg_mem_go,
    input wire logic reset_pin_n,
    input wire logic irq_pin_n,
    input wire logic lvm_low,
    input wire logic rti_irq,
    input wire logic adc_irq,
    input wire logic kbi_irq,
    output lps_pkg::lps_power_t pwr,
    output lps_pkg::lps_mode_t mode,
    output logic illegal_op_reset,
    output logic wake_reset,
    output logic wake_irq,
    output logic lvm_irq,
    output logic lvm_reset
);
    typedef struct packed {
        lps_pkg::lps_mode_t mode;
        logic [lps_pkg::CTRL_W-1:0] ctrl;
        logic dbg_entry;
        logic wake_flag;
        logic latch;
        logic lvm_prev;
        logic [31:0] rdata;
        logic illegal_rst;
        logic wake_rst;
        logic wake_irq;
        logic lvm_irq;
        logic lvm_rst;
        logic rsp_valid;
        lps_pkg::lps_rsp_t rsp;
        logic mem_go;
        lps_pkg::lps_power_t pwr;
    } lps_state_t;

    lps_state_t st_r;
    lps_state_t st_nxt;
    logic [2:0] pins_s;
    logic rst_pin_s;
    logic irq_pin_s;
    logic lvm_low_s;
    logic acc;
    logic unmapped;

    // power state of every block for a given mode and settings
    function automatic lps_pkg::lps_power_t power_of(
        input lps_pkg::lps_mode_t m,
        input logic [lps_pkg::CTRL_W-1:0] c,
        input logic dbg
    );
        lps_pkg::lps_power_t p;
        logic lvm_stop;
        lvm_stop = c[lps_pkg::CTRL_LVM_EN] & c[lps_pkg::CTRL_LVM_STOP];
        p.debug_clk_en = 1'b1;
        p.periph_clk_en = 1'b1;
        p.ics_on = 1'b1;
        p.reg_full = 1'b1;
        p.rti_on = c[lps_pkg::CTRL_RTI_EN];
        p.pin_hold = 1'b0;
        p.cpu_flash = lps_pkg::PWR_ON;
        p.ram = lps_pkg::PWR_ON;
        p.ports = lps_pkg::PWR_ON;
        p.timers = lps_pkg::PWR_ON;
        p.adc = lps_pkg::PWR_ON;
        case (m)
            lps_pkg::LPS_LIGHT:
            begin
                p.debug_clk_en = dbg;
                p.periph_clk_en = 1'b0;
                p.ics_on = dbg | c[lps_pkg::CTRL_ICS_RUN];
                p.reg_full = dbg | lvm_stop;
                p.pin_hold = 1'b1;
                p.cpu_flash = lps_pkg::PWR_STANDBY;
                p.ram = lps_pkg::PWR_STANDBY;
                p.ports = lps_pkg::PWR_STANDBY;
                p.timers = lps_pkg::PWR_STANDBY;
                p.adc = (c[lps_pkg::CTRL_ADC_ASYNC] &&
                    c[lps_pkg::CTRL_LVM_EN]) ? lps_pkg::PWR_ON :
                    lps_pkg::PWR_STANDBY;
            end
            lps_pkg::LPS_DEEP:
            begin
                p.debug_clk_en = 1'b0;
                p.periph_clk_en = 1'b0;
                p.ics_on = 1'b0;
                p.reg_full = 1'b0;
                p.pin_hold = 1'b1;
                p.cpu_flash = lps_pkg::PWR_OFF;
                p.ram = lps_pkg::PWR_STANDBY;
                p.ports = lps_pkg::PWR_OFF;
                p.timers = lps_pkg::PWR_OFF;
                p.adc = lps_pkg::PWR_OFF;
            end
            default:
            begin
                p.rti_on = c[lps_pkg::CTRL_RTI_EN];
            end
        endcase
        return p;
    endfunction

    // pins come from outside the clock domain
    lps_sync #(
        .W(3),
        .INIT(lps_pkg::PIN_SYNC_RST)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d({lvm_low, irq_pin_n, reset_pin_n}),
        .q(pins_s)
    );

    // synchronised pin levels
    assign rst_pin_s = ~pins_s[0];
    assign irq_pin_s = ~pins_s[1];
    assign lvm_low_s = pins_s[2];

    // zero-wait slave; read word was captured in the setup cycle
    assign acc = psel & penable & ce;
    assign unmapped = (paddr != lps_pkg::LPS_CTRL_OFS) &&
        (paddr != lps_pkg::LPS_STAT_OFS) &&
        (paddr != lps_pkg::LPS_ACK_OFS);
    assign pready = acc;
    assign pslverr = acc & unmapped;
    assign prdata = st_r.rdata;

    // next-state logic
    always_comb
    begin
        logic wr;
        logic ack;
        logic lvm_act;
        logic lvm_evt;
        logic bg_ok;
        logic deep_set;
        logic wake_l;
        st_nxt = st_r;
        wr = acc & pwrite;
        ack = 1'b0;
        deep_set = 1'b0;
        wake_l = 1'b0;
        st_nxt.illegal_rst = 1'b0;
        st_nxt.wake_rst = 1'b0;
        st_nxt.wake_irq = 1'b0;
        st_nxt.lvm_irq = 1'b0;
        st_nxt.lvm_rst = 1'b0;
        st_nxt.rsp_valid = 1'b0;
        st_nxt.rsp = lps_pkg::RSP_OK;
        st_nxt.mem_go = 1'b0;
        st_nxt.lvm_prev = lvm_low_s;
        // register access
        if (psel && !penable)
        begin
            case (paddr)
                lps_pkg::LPS_CTRL_OFS:
                    st_nxt.rdata = {23'h000000, st_r.ctrl};
                lps_pkg::LPS_STAT_OFS:
                    st_nxt.rdata = {25'h0000000, lvm_low_s, st_r.latch,
                        st_r.wake_flag, st_r.mode};
                default:
                    st_nxt.rdata = 32'h00000000;
            endcase
        end
        if (wr && paddr == lps_pkg::LPS_CTRL_OFS)
            st_nxt.ctrl = pwdata[lps_pkg::CTRL_W-1:0];
        if (wr && paddr == lps_pkg::LPS_ACK_OFS)
            ack = pwdata[lps_pkg::ACK_PD];
        // monitor event; in stop it needs the monitor-in-stop enable too
        lvm_act = st_r.ctrl[lps_pkg::CTRL_LVM_EN] &&
            (st_r.mode == lps_pkg::LPS_RUN ||
            st_r.mode == lps_pkg::LPS_DEBUG ||
            st_r.ctrl[lps_pkg::CTRL_LVM_STOP]);
        lvm_evt = lvm_act & lvm_low_s & ~st_r.lvm_prev;
        st_nxt.lvm_rst = lvm_evt & st_r.ctrl[lps_pkg::CTRL_LVM_RST];
        st_nxt.lvm_irq = lvm_evt & ~st_r.ctrl[lps_pkg::CTRL_LVM_RST];
        // debug command answer, by current mode
        bg_ok = 1'b0;
        if (dbg_cmd_valid)
        begin
            st_nxt.rsp_valid = 1'b1;
            st_nxt.rsp = lps_pkg::RSP_REJECT;
            case (st_r.mode)
                lps_pkg::LPS_RUN:
                begin
                    // non-intrusive commands while running, plus background when debug enabled
                    if (dbg_cmd == lps_pkg::CMD_MEM ||
                        dbg_cmd == lps_pkg::CMD_MEM_STAT ||
                        dbg_cmd == lps_pkg::CMD_BDC_REG)
                    begin
                        st_nxt.rsp = lps_pkg::RSP_OK;
                        st_nxt.mem_go = dbg_cmd != lps_pkg::CMD_BDC_REG;
                    end
                    if (dbg_cmd == lps_pkg::CMD_BACKGROUND &&
                        st_r.ctrl[lps_pkg::CTRL_DBG_EN])
                    begin
                        bg_ok = 1'b1;
                        st_nxt.rsp = lps_pkg::RSP_OK;
                    end
                end
                lps_pkg::LPS_LIGHT,
                lps_pkg::LPS_DEEP:
                begin
                    if (dbg_cmd == lps_pkg::CMD_MEM_STAT)
                        st_nxt.rsp = lps_pkg::RSP_STOPPED;
                    // deep stop never has the debug clocks running
                    if (dbg_cmd == lps_pkg::CMD_BACKGROUND &&
                        st_r.mode == lps_pkg::LPS_LIGHT &&
                        st_r.dbg_entry &&
                        st_r.ctrl[lps_pkg::CTRL_DBG_EN])
                    begin
                        bg_ok = 1'b1;
                        st_nxt.rsp = lps_pkg::RSP_OK;
                    end
                end
                default:
                begin
                    // debug mode serves every command type
                    st_nxt.rsp = lps_pkg::RSP_OK;
                    st_nxt.mem_go = dbg_cmd == lps_pkg::CMD_MEM ||
                        dbg_cmd == lps_pkg::CMD_MEM_STAT;
                end
            endcase
        end
        // mode sequencing
        case (st_r.mode)
            lps_pkg::LPS_RUN:
            begin
                if (bg_ok)
                    st_nxt.mode = lps_pkg::LPS_DEBUG;
                else if (cpu_stop_exec)
                begin
                    if (!st_r.ctrl[lps_pkg::CTRL_STOP_EN])
                        st_nxt.illegal_rst = 1'b1;
                    else if (st_r.ctrl[lps_pkg::CTRL_PDS] &&
                        !st_r.ctrl[lps_pkg::CTRL_DBG_EN] &&
                        !(st_r.ctrl[lps_pkg::CTRL_LVM_EN] &&
                        st_r.ctrl[lps_pkg::CTRL_LVM_STOP]))
                    begin
                        st_nxt.mode = lps_pkg::LPS_DEEP;
                        st_nxt.latch = 1'b1;
                    end
                    else
                        st_nxt.mode = lps_pkg::LPS_LIGHT;
                    st_nxt.dbg_entry = st_r.ctrl[lps_pkg::CTRL_DBG_EN];
                end
            end
            lps_pkg::LPS_LIGHT:
            begin
                wake_l = (st_r.ctrl[lps_pkg::CTRL_RTI_EN] && rti_irq) ||
                    st_nxt.lvm_irq || adc_irq || irq_pin_s || kbi_irq;
                if (rst_pin_s || st_nxt.lvm_rst)
                begin
                    st_nxt.mode = lps_pkg::LPS_RUN;
                    st_nxt.wake_rst = rst_pin_s;
                end
                else if (bg_ok)
                    st_nxt.mode = lps_pkg::LPS_DEBUG;
                else if (wake_l)
                begin
                    st_nxt.mode = lps_pkg::LPS_RUN;
                    st_nxt.wake_irq = 1'b1;
                end
            end
            lps_pkg::LPS_DEEP:
            begin
                // deep wake restarts as from power-on; latches stay
                if (rst_pin_s || irq_pin_s ||
                    (st_r.ctrl[lps_pkg::CTRL_RTI_EN] && rti_irq))
                begin
                    st_nxt.mode = lps_pkg::LPS_RUN;
                    st_nxt.wake_rst = 1'b1;
                    st_nxt.ctrl = lps_pkg::CTRL_RST;
                    deep_set = 1'b1;
                end
            end
            default:
            begin
                if (dbg_cmd_valid && dbg_cmd == lps_pkg::CMD_GO)
                    st_nxt.mode = lps_pkg::LPS_RUN;
            end
        endcase
        // set wins over the acknowledge clear
        st_nxt.wake_flag = deep_set | (st_r.wake_flag & ~ack);
        st_nxt.latch = st_nxt.latch & ~(ack & ~deep_set &
            st_r.mode != lps_pkg::LPS_DEEP);
        st_nxt.pwr = power_of(st_nxt.mode, st_nxt.ctrl, st_nxt.dbg_entry);
        st_nxt.pwr.pin_hold = st_nxt.pwr.pin_hold | st_nxt.latch;
    end

    // state register; clock enable freezes everything
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.mode <= lps_pkg::LPS_RUN;
            st_r.ctrl <= lps_pkg::CTRL_RST;
            st_r.lvm_prev <= 1'b1;
            st_r.pwr.debug_clk_en <= 1'b1;
            st_r.pwr.periph_clk_en <= 1'b1;
            st_r.pwr.ics_on <= 1'b1;
            st_r.pwr.reg_full <= 1'b1;
        end
        else if (ce)
            st_r <= st_nxt;
    end

    // outputs straight from state flops
    assign pwr = st_r.pwr;
    assign mode = st_r.mode;
    assign illegal_op_reset = st_r.illegal_rst;
    assign wake_reset = st_r.wake_rst;
    assign wake_irq = st_r.wake_irq;
    assign lvm_irq = st_r.lvm_irq;
    assign lvm_reset = st_r.lvm_rst;
    assign dbg_rsp_valid = st_r.rsp_valid;
    assign dbg_rsp = st_r.rsp;
    assign dbg_mem_go = st_r.mem_go;
endmodule

// ===== testbench/lps_host_model.sv
// cpu core and debug host stand-in driving stop and command strobes
`timescale 1ns/100ps
module lps_host_model (
    input wire logic pclk,
    output logic cpu_stop_exec,
    output logic dbg_cmd_valid,
    output lps_pkg::lps_cmd_t dbg_cmd
);
    // strobes idle low from time zero
    initial
    begin
        cpu_stop_exec = 1'b0;
        dbg_cmd_valid = 1'b0;
        dbg_cmd = lps_pkg::CMD_GO;
    end
    // one-cycle stop strobe, changed only after an edge
    task automatic stop();
        @(posedge pclk);
        cpu_stop_exec <= 1'b1;
        @(posedge pclk);
        cpu_stop_exec <= 1'b0;
    endtask
    // one-cycle command; released bus shows the inverse, not stale data
    task automatic cmd(input lps_pkg::lps_cmd_t c);
        @(posedge pclk);
        dbg_cmd_valid <= 1'b1;
        dbg_cmd <= c;
        @(posedge pclk);
        dbg_cmd_valid <= 1'b0;
        dbg_cmd <= lps_pkg::lps_cmd_t'(~c);
    endtask
endmodule

// ===== testbench/lps_asserts.sv
// concurrent checks on the stop-mode controller ports
`timescale 1ns/100ps
module lps_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic cpu_stop_exec,
    input wire logic dbg_cmd_valid,
    input wire lps_pkg::lps_cmd_t dbg_cmd,
    input wire logic dbg_rsp_valid,
    input wire lps_pkg::lps_rsp_t dbg_rsp,
    input wire logic dbg_mem_go,
    input wire lps_pkg::lps_power_t pwr,
    input wire lps_pkg::lps_mode_t mode,
    input wire logic illegal_op_reset
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic lt;
    logic dp;
    // mode decode used by most checks
    assign lt = mode == lps_pkg::LPS_LIGHT;
    assign dp = mode == lps_pkg::LPS_DEEP;
    sequence s_cmd(c);
        ce && dbg_cmd_valid && dbg_cmd == c;
    endsequence
    sequence s_stop_req;
        ce && mode == lps_pkg::LPS_RUN && cpu_stop_exec && !dbg_cmd_valid;
    endsequence
    periph_gate_a: assert property ((lt || dp) |-> !pwr.periph_clk_en)
        else $error("peripheral clock runs in stop");
    deep_off_a: assert property (dp |-> !pwr.reg_full && pwr.pin_hold
        && pwr.cpu_flash == lps_pkg::PWR_OFF
        && pwr.timers == lps_pkg::PWR_OFF
        && pwr.ram == lps_pkg::PWR_STANDBY)
        else $error("deep stop power levels wrong");
    light_stby_a: assert property (lt |-> pwr.pin_hold
        && pwr.cpu_flash == lps_pkg::PWR_STANDBY)
        else $error("light stop power levels wrong");
    dbg_light_a: assert property (lt && pwr.debug_clk_en
        |-> pwr.reg_full && pwr.ics_on)
        else $error("debug light stop lost regulator or clock");
    deep_nodbg_a: assert property (dp |-> !pwr.debug_clk_en)
        else $error("deep stop entered with debug clocks");
    stat_err_a: assert property (lt ##0 s_cmd(lps_pkg::CMD_MEM_STAT)
        |=> dbg_rsp_valid && dbg_rsp == lps_pkg::RSP_STOPPED && !dbg_mem_go)
        else $error("status command in stop not refused");
    bg_refuse_a: assert property (lt && !pwr.debug_clk_en
        ##0 s_cmd(lps_pkg::CMD_BACKGROUND) |=> mode != lps_pkg::LPS_DEBUG)
        else $error("background woke without debug enable");
    dbg_all_a: assert property (mode == lps_pkg::LPS_DEBUG
        && ce && dbg_cmd_valid |=> dbg_rsp_valid && dbg_rsp == lps_pkg::RSP_OK)
        else $error("command refused in debug mode");
    illegal_a: assert property (illegal_op_reset
        |-> $past(cpu_stop_exec) && mode == lps_pkg::LPS_RUN)
        else $error("illegal opcode reset without stop");
    stop_enter_a: assert property (s_stop_req
        |=> lt || dp || illegal_op_reset)
        else $error("stop instruction ignored");
endmodule

bind lps_stop_ctrl lps_asserts lps_asserts_inst (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .cpu_stop_exec(cpu_stop_exec),
    .dbg_cmd_valid(dbg_cmd_valid),
    .dbg_cmd(dbg_cmd),
    .dbg_rsp_valid(dbg_rsp_valid),
    .dbg_rsp(dbg_rsp),
    .dbg_mem_go(dbg_mem_go),
    .pwr(pwr),
    .mode(mode),
    .illegal_op_reset(illegal_op_reset)
);

// ===== testbench/tb_top.sv
// self-checking bench for the stop-mode controller
`timescale 1ns/100ps
module tb_top;
    localparam logic [31:0] C_DBG = 32'h0000_0001;
    localparam logic [31:0] C_LVM = 32'h0000_0006;
    localparam logic [31:0] C_PDS = 32'h0000_0008;
    localparam logic [31:0] C_SEN = 32'h0000_0010;
    localparam logic [31:0] C_RUNA = 32'h0000_0060;
    localparam logic [31:0] C_LRS = 32'h0000_0082;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cpu_stop_exec, dbg_cmd_valid, dbg_rsp_valid, dbg_mem_go;
    lps_pkg::lps_cmd_t dbg_cmd;
    lps_pkg::lps_rsp_t dbg_rsp;
    logic reset_pin_n, irq_pin_n, lvm_low, rti_irq, adc_irq, kbi_irq;
    lps_pkg::lps_power_t pwr;
    lps_pkg::lps_mode_t mode;
    logic illegal_op_reset, wake_reset, wake_irq, lvm_irq, lvm_reset;
    int fails, cmp_count;

    lps_stop_ctrl lps_stop_ctrl_inst (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_stop_exec(cpu_stop_exec),
        .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd(dbg_cmd),
        .dbg_rsp_valid(dbg_rsp_valid), .dbg_rsp(dbg_rsp),
        .dbg_mem_go(dbg_mem_go), .reset_pin_n(reset_pin_n),
        .irq_pin_n(irq_pin_n), .lvm_low(lvm_low), .rti_irq(rti_irq),
        .adc_irq(adc_irq), .kbi_irq(kbi_irq), .pwr(pwr), .mode(mode),
        .illegal_op_reset(illegal_op_reset), .wake_reset(wake_reset),
        .wake_irq(wake_irq), .lvm_irq(lvm_irq), .lvm_reset(lvm_reset));
    lps_host_model lps_host_model_inst (.pclk(pclk),
        .cpu_stop_exec(cpu_stop_exec), .dbg_cmd_valid(dbg_cmd_valid),
        .dbg_cmd(dbg_cmd));

    // 25 MHz bus clock
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // apb master: request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'(pready), 32'h0000_0001);
        if (n >= 20)
            finish_test();
    endtask

    // bounded wait for a mode, a stuck wait ends the run
    task automatic wait_mode(input lps_pkg::lps_mode_t m);
        int n;
        n = 0;
        while (mode !== m && n < 50)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk("mode", 32'(mode), 32'(m));
        if (n >= 50)
            finish_test();
    endtask

    task automatic send(input lps_pkg::lps_cmd_t c,
        input lps_pkg::lps_rsp_t e);
        lps_host_model_inst.cmd(c);
        #1;
        chk("rsp", 32'({dbg_rsp_valid, dbg_rsp}), 32'({1'b1, e}));
    endtask

    task automatic stop_in(input logic [31:0] c, lps_pkg::lps_mode_t m);
        apb(1'b1, lps_pkg::LPS_CTRL_OFS, c);
        lps_host_model_inst.stop();
        #1;
        chk("stop mode", 32'(mode), 32'(m));
    endtask

    task automatic t_regs();
        apb(1'b1, lps_pkg::LPS_CTRL_OFS, 32'hFFFF_FFFF);
        apb(1'b0, lps_pkg::LPS_CTRL_OFS, 32'h0000_0000);
        chk("ctrl", rd, 32'h0000_01FF);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk("slverr", 32'(err), 32'h0000_0001);
        apb(1'b1, lps_pkg::LPS_CTRL_OFS, 32'h0000_0000);
        send(lps_pkg::CMD_BACKGROUND, lps_pkg::RSP_REJECT);
        apb(1'b1, lps_pkg::LPS_CTRL_OFS, C_DBG);
        send(lps_pkg::CMD_BACKGROUND, lps_pkg::RSP_OK);
        wait_mode(lps_pkg::LPS_DEBUG);
        send(lps_pkg::CMD_GO, lps_pkg::RSP_OK);
        $display("test regs done");
    endtask

    task automatic t_deep();
        stop_in(C_PDS, lps_pkg::LPS_RUN);
        chk("illegal", 32'(illegal_op_reset), 32'h0000_0001);
        stop_in(C_PDS | C_SEN, lps_pkg::LPS_DEEP);
        @(posedge pclk);
        reset_pin_n <= 1'b0;
        wait_mode(lps_pkg::LPS_RUN);
        chk("wake rst", 32'(wake_reset), 32'h0000_0001);
        chk("hold", 32'(pwr.pin_hold), 32'h0000_0001);
        @(posedge pclk);
        reset_pin_n <= 1'b1;
        apb(1'b0, lps_pkg::LPS_STAT_OFS, 32'h0000_0000);
        chk("stat", rd, 32'h0000_0031);
        apb(1'b1, lps_pkg::LPS_ACK_OFS, 32'h0000_0001);
        apb(1'b0, lps_pkg::LPS_STAT_OFS, 32'h0000_0000);
        chk("stat ack", rd, 32'h0000_0001);
        chk("hold ack", 32'(pwr.pin_hold), 32'h0000_0000);
        $display("test deep done");
    endtask

    task automatic t_dbg_light();
        stop_in(C_DBG | C_LVM | C_PDS | C_SEN, lps_pkg::LPS_LIGHT);
        chk("pwr", 32'({pwr.debug_clk_en, pwr.periph_clk_en, pwr.ics_on,
            pwr.reg_full}), 32'h0000_000B);
        send(lps_pkg::CMD_MEM_STAT, lps_pkg::RSP_STOPPED);
        chk("mem go", 32'(dbg_mem_go), 32'h0000_0000);
        send(lps_pkg::CMD_BACKGROUND, lps_pkg::RSP_OK);
        wait_mode(lps_pkg::LPS_DEBUG);
        for (int i = 0; i < 6; i++)
            send(lps_pkg::lps_cmd_t'(i), lps_pkg::RSP_OK);
        send(lps_pkg::CMD_GO, lps_pkg::RSP_OK);
        $display("test debug light done");
    endtask

    task automatic t_lvm_light();
        stop_in(C_LVM | C_PDS | C_SEN, lps_pkg::LPS_LIGHT);
        chk("pwr", 32'({pwr.ics_on, pwr.reg_full, pwr.adc}),
            32'h0000_0005);
        send(lps_pkg::CMD_BACKGROUND, lps_pkg::RSP_REJECT);
        chk("mode", 32'(mode), 32'(lps_pkg::LPS_LIGHT));
        @(posedge pclk);
        kbi_irq <= 1'b1;
        wait_mode(lps_pkg::LPS_RUN);
        chk("wake irq", 32'(wake_irq), 32'h0000_0001);
        @(posedge pclk);
        kbi_irq <= 1'b0;
        stop_in(C_LVM | C_PDS | C_SEN | C_RUNA, lps_pkg::LPS_LIGHT);
        chk("pwr", 32'({pwr.ics_on, pwr.adc}), 32'h0000_0004);
        @(posedge pclk);
        adc_irq <= 1'b1;
        wait_mode(lps_pkg::LPS_RUN);
        chk("adc wake", 32'(wake_irq), 32'h0000_0001);
        @(posedge pclk);
        adc_irq <= 1'b0;
        apb(1'b1, lps_pkg::LPS_CTRL_OFS, C_LRS);
        lvm_low <= 1'b1;
        err = 1'b0;
        rd = 32'h0000_0000;
        repeat (8)
        begin
            @(posedge pclk);
            #1;
            err |= lvm_reset;
            rd[0] |= lvm_irq;
        end
        chk("lvm reset", 32'(err), 32'h0000_0001);
        chk("lvm irq", rd, 32'h0000_0000);
        $display("test monitor light done");
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        reset_pin_n = 1'b1;
        irq_pin_n = 1'b1;
        lvm_low = 1'b0;
        rti_irq = 1'b0;
        adc_irq = 1'b0;
        kbi_irq = 1'b0;
        fails = 0;
        cmp_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_deep();
        t_dbg_light();
        t_lvm_light();
        finish_test();
    end
endmodule
